/* File: scm_pkg.sv */
package scm_pkg;
	// Data width of every register
	localparam int DW = 16;
	// Clock and one-second tick
	localparam int CLK_MHZ = 200;
	localparam int ONE_SEC_MS = 1000;
	localparam int TICK_CYC = ONE_SEC_MS * 1000 * CLK_MHZ;
	// Mode exit needs more than one second: two ticks
	localparam logic [1:0] MODE_EXIT_TICKS = 2'h2;
	// Learning interval units and test interval
	localparam logic [31:0] SEC_PER_MIN = 32'h3c;
	localparam logic [15:0] TEST_IVL_CODE = 16'hfa;
	localparam logic [31:0] TEST_IVL_MIN = 32'ha;
	// Energy scale: C(0.1F)*dV^2(mV^2) vs P(mW)*T(s)
	localparam logic [63:0] ENERGY_SCALE = 64'h4e20;
	// Register indices
	localparam int NREG = 28;
	localparam logic [4:0] A_CTRL = 5'h00, A_LRN_IVL = 5'h01, A_LRN_DUR = 5'h02;
	localparam logic [4:0] A_MAX_CHG_T = 5'h03, A_MAX_DSG_T = 5'h04, A_CAP = 5'h06;
	localparam logic [4:0] A_RELATIVE_CHARGE_PERCENT = 5'h07, A_ESR = 5'h08, A_ESR_OFS = 5'h09;
	localparam logic [4:0] A_CHG_THR = 5'h0a, A_DSG_THR = 5'h0b, A_BAL_THR = 5'h0c;
	localparam logic [4:0] A_BAL_MIN = 5'h0d, A_BAL_RST = 5'h0e, A_FMASK = 5'h0f;
	localparam logic [4:0] A_STATUS = 5'h10, A_CHG_V = 5'h11, A_CHG_I = 5'h12;
	localparam logic [4:0] A_MIN_V = 5'h13, A_V_LRN_MAX = 5'h14, A_V_NOM = 5'h15;
	localparam logic [4:0] A_MIN_PWR = 5'h19, A_REQ_T = 5'h1a, A_INIT_ESR = 5'h1b;
	// Control bits
	localparam int C_LEARN = 0, C_BAL_EN = 1, C_STACK = 2, C_UNSEAL = 3;
	// Status bits
	localparam int S_LIP = 0, S_LEARN_PASSED_FLAG = 1, S_LEARN_DISCHARGE_TIMEOUT_FLAG = 2, S_LEARN_CHARGE_TIMEOUT_FLAG = 3, S_DSG = 4;
	localparam int S_CHG = 5, S_FC = 6, S_BAL = 7, S_HEALTH_LOW_FLAG = 8, S_HEALTH_WARNING_FLAG = 9;
	localparam int S_HEALTH_FAIL_FLAG = 10;
	// Reset values, by index
	localparam logic [15:0] RST_VAL [NREG] = '{
		16'h0000, 16'h0a80, 16'h0e10, 16'h0258, 16'h0258, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064, 16'h0a28, 16'h000a,
		16'h001e, 16'h0007, 16'h0000, 16'h0000, 16'h01f4, 16'h1388, 16'h2710,
		16'h2328, 16'h2454, 16'h2580, 16'h26ac, 16'h1388, 16'h000a, 16'h0000};
	// Learning sequence states
	typedef enum logic [2:0] {
		LS_IDLE, LS_CHG1, LS_DSG1, LS_CHG2, LS_DSG2, LS_CALC, LS_HOLD
	} scm_lstate_e;
endpackage : scm_pkg

/* File: scm_div.sv */
`timescale 1ns/100ps
`default_nettype none
// Restoring divider, one quotient bit per cycle
module scm_div #(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Request
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	// Answer
	output logic busy,
	output logic done,
	output logic [W-1:0] quo
);
	logic [W-1:0] rem_q; // Partial remainder
	logic [W-1:0] den_q; // Held divisor
	logic [$clog2(W+1)-1:0] cnt_q; // Bits left
	logic [W:0] trial; // Shifted remainder

	// Next trial value
	always_comb begin
		trial = {rem_q, quo[W-1]};
	end

	////////////////////////////////////////////////////////////////
	// Iteration; zero divisor yields all ones
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rem_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			quo <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				rem_q <= '0;
				den_q <= den;
				quo <= num;
				cnt_q <= ($clog2(W+1))'(W);
				busy <= 1'b1;
			end else if (busy) begin
				if (trial >= {1'b0, den_q}) begin
					rem_q <= W'(trial - {1'b0, den_q});
					quo <= {quo[W-2:0], 1'b1};
				end else begin
					rem_q <= trial[W-1:0];
					quo <= {quo[W-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == 1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : scm_div
`default_nettype wire

/* File: scm_manager.sv */
`timescale 1ns/100ps
`default_nettype none
module scm_manager import scm_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int NCAP = 5
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port
	input wire logic [4:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rd_data,
	// Measurements
	input wire logic [15:0] stack_mv,
	input wire logic signed [15:0] current_ma,
	input wire logic [NCAP-1:0][15:0] cap_mv,
	input wire logic meas_busy,
	input wire logic full_charge_flag,
	input wire logic [15:0] init_cap_dfarad,
	// Nonvolatile store
	output logic nv_cap_wr,
	output logic [15:0] nv_cap_data,
	// Pins
	output logic load_enable_out,
	output logic fault_out,
	output logic charge_level_bit_high,
	output logic charge_level_bit_low,
	output logic [NCAP-2:0] bypass_out,
	output logic bottom_cap_bypass_out
);
	logic [15:0] cfg_q [NREG]; // Register store
	logic [31:0] tick_cnt_q; // Tick divider
	logic tick_q; // One-second pulse
	logic init_done_q; // Capacitance loaded
	logic [15:0] cap_q; // Learned capacitance
	logic [15:0] relative_charge_percent_q; // Charge percent
	logic [15:0] esr_q, init_esr_q; // Resistance, mOhm
	logic init_esr_set_q; // First ESR stored
	logic learn_req_q, bal_en_q; // Commands
	logic lip_q, learn_passed_flag_q, learn_discharge_timeout_flag_q, learn_charge_timeout_flag_q; // Learn flags
	logic health_low_flag_q, health_warning_flag_q, health_fail_flag_q; // Health flags
	logic dsg_q, chg_q; // Current modes
	logic [1:0] dsg_x_q, chg_x_q; // Mode exit counts
	logic bal_q; // Balancing active
	logic [1:0] lvl_q; // Chosen charge level
	scm_lstate_e ls_q; // Learn state
	logic [31:0] ivl_q, ph_q, lt_q; // Interval, phase, learn timers
	logic [15:0] va_q, t_dsg_q; // Captured voltage, time
	logic esr_cap_q; // ESR sample taken
	logic stack, unseal; // Config bits
	logic [31:0] ivl_s; // Interval, seconds
	logic [15:0] chg_v, i_mag, vmax, vmin, spread;
	logic [3:0] lvl_ok; // Level meets energy need
	logic [1:0] lvl_sel;
	logic learn_go;
	logic cap_done, relative_charge_percent_done, esr_done, relative_charge_percent_busy;
	logic [39:0] cap_quo;
	logic [23:0] relative_charge_percent_quo;
	logic [31:0] esr_quo;
	logic cap_start, esr_start;
	logic dsg_now; // Discharge current seen this cycle

	assign stack = cfg_q[A_CTRL][C_STACK];
	assign unseal = cfg_q[A_CTRL][C_UNSEAL];
	assign chg_v = cfg_q[A_V_NOM + 5'(lvl_q)];
	assign i_mag = current_ma[15] ? 16'(-current_ma) : current_ma;

	////////////////////////////////////////////////////////////////
	// One-second tick
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Register writes and commands
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			for (int i = 0; i < NREG; i++) begin
				cfg_q[i] <= RST_VAL[i];
			end
		end else if (wr_en && addr < 5'(NREG)) begin
			cfg_q[addr] <= wr_data;
		end
	end

	// Learn request and sticky balance enable; request wins over take
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			learn_req_q <= 1'b0;
			bal_en_q <= 1'b0;
		end else begin
			if (wr_en && addr == A_CTRL && wr_data[C_LEARN]) begin
				learn_req_q <= 1'b1;
			end else if (learn_go) begin
				learn_req_q <= 1'b0;
			end
			if (wr_en && addr == A_CTRL && wr_data[C_BAL_EN]) begin
				bal_en_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port, data only in the next cycle
	always_ff @(posedge mclk) begin
		if (!rst_b || !rd_en) begin
			rd_data <= '0;
		end else begin
			unique case (addr)
				A_CTRL: rd_data <= {11'h0, cfg_q[A_CTRL][4:2], bal_en_q, 1'b0};
				A_CAP: rd_data <= cap_q;
				A_RELATIVE_CHARGE_PERCENT: rd_data <= relative_charge_percent_q;
				A_ESR: rd_data <= esr_q;
				A_INIT_ESR: rd_data <= init_esr_q;
				A_CHG_V: rd_data <= chg_v;
				A_STATUS: rd_data <= {5'h0, health_fail_flag_q, health_warning_flag_q, health_low_flag_q, bal_q,
					full_charge_flag, chg_q, dsg_q, learn_charge_timeout_flag_q, learn_discharge_timeout_flag_q, learn_passed_flag_q, lip_q};
				default: rd_data <= (addr < 5'(NREG)) ? cfg_q[addr] : 16'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Learning interval; code 250 unsealed is ten minutes
	always_comb begin
		if (unseal && cfg_q[A_LRN_IVL] == TEST_IVL_CODE) begin
			ivl_s = TEST_IVL_MIN * SEC_PER_MIN;
		end else begin
			ivl_s = 32'(cfg_q[A_LRN_IVL]) * SEC_PER_MIN;
		end
	end

	// Start on command or after a full interval since reset or last learn
	assign learn_go = ls_q == LS_IDLE && (learn_req_q || ivl_q >= ivl_s);

	// Interval counter, restarted by each learn
	always_ff @(posedge mclk) begin
		if (!rst_b || ls_q != LS_IDLE) begin
			ivl_q <= '0;
		end else if (tick_q) begin
			ivl_q <= ivl_q + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Learning sequence
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ls_q <= LS_IDLE;
			lip_q <= 1'b0;
			learn_passed_flag_q <= 1'b0;
			learn_discharge_timeout_flag_q <= 1'b0;
			learn_charge_timeout_flag_q <= 1'b0;
			ph_q <= '0;
			lt_q <= '0;
			va_q <= '0;
			t_dsg_q <= '0;
			esr_cap_q <= 1'b0;
		end else begin
			if (tick_q) begin
				ph_q <= ph_q + 32'h1;
				lt_q <= lt_q + 32'h1;
			end
			unique case (ls_q)
				LS_IDLE: begin
					if (learn_go) begin
						ls_q <= LS_CHG1;
						lip_q <= 1'b1;
						learn_passed_flag_q <= 1'b0;
						learn_discharge_timeout_flag_q <= 1'b0;
						learn_charge_timeout_flag_q <= 1'b0;
						ph_q <= '0;
						lt_q <= '0;
					end
				end
				LS_CHG1, LS_CHG2: begin
					if (tick_q && ph_q > 32'(cfg_q[A_MAX_CHG_T])) begin
						learn_charge_timeout_flag_q <= 1'b1;
						lip_q <= 1'b0;
						ls_q <= LS_IDLE;
					end else if (stack_mv >= cfg_q[A_V_LRN_MAX]) begin
						ls_q <= (ls_q == LS_CHG1) ? LS_DSG1 : LS_DSG2;
						ph_q <= '0;
						va_q <= stack_mv;
						esr_cap_q <= 1'b0;
					end
				end
				LS_DSG1: begin
					if (tick_q && ph_q > 32'(cfg_q[A_MAX_DSG_T])) begin
						learn_discharge_timeout_flag_q <= 1'b1;
						lip_q <= 1'b0;
						ls_q <= LS_IDLE;
					end else if (stack_mv <= chg_v && ph_q != 0) begin
						t_dsg_q <= ph_q[15:0];
						ls_q <= LS_CHG2;
						ph_q <= '0;
					end
				end
				LS_DSG2: begin
					if (tick_q && ph_q > 32'(cfg_q[A_MAX_DSG_T])) begin
						learn_discharge_timeout_flag_q <= 1'b1;
						lip_q <= 1'b0;
						ls_q <= LS_IDLE;
					end else if (tick_q && !esr_cap_q) begin
						esr_cap_q <= 1'b1;
						ls_q <= LS_CALC;
					end
				end
				LS_CALC: begin
					if (cap_done) begin
						ls_q <= LS_HOLD;
					end
				end
				LS_HOLD: begin
					if (lt_q >= 32'(cfg_q[A_LRN_DUR])) begin
						ls_q <= LS_IDLE;
						lip_q <= 1'b0;
						learn_passed_flag_q <= 1'b1;
					end
				end
				default: ls_q <= LS_IDLE;
			endcase
		end
	end

	// Capacitance: I*t/dV, in tenths of a farad
	assign cap_start = ls_q == LS_DSG2 && tick_q && !esr_cap_q;
	// Resistance: load step drop over current, in mOhm
	assign esr_start = cap_start;

	scm_div #(.W(40)) u_cap_div (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(cap_start),
		.num(40'(i_mag) * 40'(t_dsg_q) * 40'ha),
		.den(40'(va_q - chg_v)),
		.busy(),
		.done(cap_done),
		.quo(cap_quo)
	);

	scm_div #(.W(32)) u_esr_div (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(esr_start),
		.num(32'(va_q - stack_mv) * 32'h3e8),
		.den(32'(i_mag)),
		.busy(),
		.done(esr_done),
		.quo(esr_quo)
	);

	scm_div #(.W(24)) u_relative_charge_percent_div (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(tick_q),
		.num(stack_mv > cfg_q[A_MIN_V] ? 24'(stack_mv - cfg_q[A_MIN_V]) * 24'h64 : 24'h0),
		.den(chg_v > cfg_q[A_MIN_V] ? 24'(chg_v - cfg_q[A_MIN_V]) : 24'h0),
		.busy(relative_charge_percent_busy),
		.done(relative_charge_percent_done),
		.quo(relative_charge_percent_quo)
	);

	////////////////////////////////////////////////////////////////
	// Energy check per charging level: first level that suffices
	for (genvar g = 0; g < 4; g++) begin : g_lvl
		logic [15:0] v;
		assign v = cfg_q[A_V_NOM + 5'(g)];
		assign lvl_ok[g] = v > cfg_q[A_MIN_V] && 64'(cap_quo[15:0]) *
			(64'(v) * 64'(v) - 64'(cfg_q[A_MIN_V]) * 64'(cfg_q[A_MIN_V])) >=
			64'(cfg_q[A_MIN_PWR]) * 64'(cfg_q[A_REQ_T]) * ENERGY_SCALE;
	end

	always_comb begin
		lvl_sel = 2'h3;
		for (int i = 3; i >= 0; i--) begin
			if (lvl_ok[i]) begin
				lvl_sel = 2'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Capacitance, charge level and health results
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			init_done_q <= 1'b0;
			cap_q <= '0;
			nv_cap_wr <= 1'b0;
			nv_cap_data <= '0;
			lvl_q <= '0;
			health_low_flag_q <= 1'b0;
			health_warning_flag_q <= 1'b0;
			health_fail_flag_q <= 1'b0;
		end else begin
			nv_cap_wr <= 1'b0;
			if (!init_done_q) begin
				init_done_q <= 1'b1;
				cap_q <= init_cap_dfarad;
			end else if (ls_q == LS_CALC && cap_done) begin
				cap_q <= cap_quo[15:0];
				nv_cap_wr <= 1'b1;
				nv_cap_data <= cap_quo[15:0];
				lvl_q <= lvl_sel;
				health_low_flag_q <= lvl_sel == 2'h1 || lvl_sel == 2'h2;
				health_warning_flag_q <= lvl_sel == 2'h3;
				health_fail_flag_q <= lvl_sel == 2'h3 && !lvl_ok[3];
			end
		end
	end

	// Charge percent, clamped at full
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			relative_charge_percent_q <= '0;
		end else if (relative_charge_percent_done) begin
			relative_charge_percent_q <= relative_charge_percent_quo > 24'h64 ? 16'h64 : relative_charge_percent_quo[15:0];
		end
	end

	// Resistance with offset; first value kept once
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			esr_q <= '0;
			init_esr_q <= '0;
			init_esr_set_q <= 1'b0;
		end else if (esr_done) begin
			esr_q <= esr_quo[15:0] + cfg_q[A_ESR_OFS];
			if (!init_esr_set_q) begin
				init_esr_q <= esr_quo[15:0];
				init_esr_set_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Current modes, evaluated each tick
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dsg_q <= 1'b0;
			chg_q <= 1'b0;
			dsg_x_q <= '0;
			chg_x_q <= '0;
		end else if (tick_q) begin
			if (current_ma < -$signed({1'b0, cfg_q[A_DSG_THR]})) begin
				dsg_q <= 1'b1;
				dsg_x_q <= '0;
			end else if (dsg_q && current_ma > $signed({1'b0, cfg_q[A_CHG_THR]})) begin
				dsg_x_q <= dsg_x_q + 2'h1;
				if (dsg_x_q + 2'h1 >= MODE_EXIT_TICKS) begin
					dsg_q <= 1'b0;
				end
			end else begin
				dsg_x_q <= '0;
			end
			if (current_ma > $signed({1'b0, cfg_q[A_CHG_THR]})) begin
				chg_q <= 1'b1;
				chg_x_q <= '0;
			end else if (chg_q && current_ma < -$signed({1'b0, cfg_q[A_DSG_THR]})) begin
				chg_x_q <= chg_x_q + 2'h1;
				if (chg_x_q + 2'h1 >= MODE_EXIT_TICKS) begin
					chg_q <= 1'b0;
				end
			end else begin
				chg_x_q <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Cell spread
	always_comb begin
		vmax = cap_mv[0];
		vmin = cap_mv[0];
		for (int i = 1; i < NCAP; i++) begin
			if (cap_mv[i] > vmax) vmax = cap_mv[i];
			if (cap_mv[i] < vmin) vmin = cap_mv[i];
		end
		spread = vmax - vmin;
	end

	// Live discharge current, not the slow mode flag, so a parked mode cannot chatter
	assign dsg_now = current_ma < -$signed({1'b0, cfg_q[A_DSG_THR]});

	// Balancing state with start-stop hysteresis
	always_ff @(posedge mclk) begin
		if (!rst_b || !bal_en_q || stack) begin
			bal_q <= 1'b0;
		end else if (bal_q && (spread < cfg_q[A_BAL_MIN] || dsg_now)) begin
			bal_q <= 1'b0;
		end else if (!dsg_now && (chg_q || full_charge_flag) &&
			spread >= cfg_q[A_BAL_RST]) begin
			bal_q <= 1'b1;
		end
	end

	// Bypass loads, off from the cycle after a measurement starts; bottom cell on own pin
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bypass_out <= '0;
			bottom_cap_bypass_out <= 1'b0;
		end else begin
			for (int i = 1; i < NCAP; i++) begin
				bypass_out[i-1] <= bal_q && !meas_busy && !stack &&
					spread > cfg_q[A_BAL_MIN] && cap_mv[i] > cfg_q[A_BAL_THR];
			end
			bottom_cap_bypass_out <= bal_q && !meas_busy && !stack &&
				spread > cfg_q[A_BAL_MIN] && cap_mv[0] > cfg_q[A_BAL_THR];
		end
	end

	////////////////////////////////////////////////////////////////
	// Pins: load enable, fault, level code
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			load_enable_out <= 1'b0;
			fault_out <= 1'b0;
			charge_level_bit_high <= 1'b0;
			charge_level_bit_low <= 1'b0;
		end else begin
			load_enable_out <= ls_q == LS_DSG1 || ls_q == LS_DSG2;
			fault_out <= |({health_fail_flag_q, health_warning_flag_q, health_low_flag_q} & cfg_q[A_FMASK][2:0]);
			charge_level_bit_high <= lvl_q[1];
			charge_level_bit_low <= lvl_q[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_learn_start;
		ls_q == LS_IDLE && learn_go;
	endsequence
	sequence s_learn_flags;
		lip_q && !learn_passed_flag_q && !learn_discharge_timeout_flag_q && !learn_charge_timeout_flag_q;
	endsequence
	AST_LEARN_START: assert property (s_learn_start |=> s_learn_flags)
		else $error("learn start flags wrong");
	AST_FAULT: assert property (##1 fault_out ==
		|($past({health_fail_flag_q, health_warning_flag_q, health_low_flag_q}) & $past(cfg_q[A_FMASK][2:0])))
		else $error("fault pin mismatch");
	AST_LEVEL: assert property ({charge_level_bit_high, charge_level_bit_low}
		== $past(lvl_q))
		else $error("level pins mismatch");
	AST_STACK_NOBAL: assert property (stack |=> ##1 !bottom_cap_bypass_out
		&& bypass_out == '0)
		else $error("bypass in stack mode");
	AST_NO_EN_NOBAL: assert property (!bal_en_q |=> ##1 bypass_out == '0)
		else $error("bypass before enable");
	AST_LOAD: assert property ($rose(load_enable_out) |->
		$past(ls_q == LS_DSG1 || ls_q == LS_DSG2))
		else $error("load pin outside discharge");
	AST_DSG_ENTER: assert property (tick_q &&
		current_ma < -$signed({1'b0, cfg_q[A_DSG_THR]}) |=> dsg_q)
		else $error("discharge mode not entered");
	AST_PASS: assert property ($rose(learn_passed_flag_q) |-> !lip_q && $past(ls_q == LS_HOLD))
		else $error("pass without hold end");
	AST_MEAS_OFF: assert property (meas_busy |=> bypass_out == '0
		&& !bottom_cap_bypass_out)
		else $error("bypass during measurement");
endmodule : scm_manager
`default_nettype wire

/* File: scm_stack_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Stack, load circuit and converter seen from the manager
module scm_stack_model import scm_pkg::*; #(
	parameter int NCAP = 5,
	parameter logic [15:0] LOAD_MA = 16'h03e8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Bench commands
	input wire logic [NCAP-1:0][15:0] cell_set,
	input wire logic signed [15:0] cur_set,
	input wire logic fc_set,
	// Manager pins
	input wire logic load_enable_out,
	// Measurements
	output logic [15:0] stack_mv,
	output logic signed [15:0] current_ma,
	output logic [NCAP-1:0][15:0] cap_mv,
	output logic meas_busy,
	output logic full_charge_flag
);
	////////////////////////////////////////
	logic [4:0] phase_q; // Conversion period counter
	// Free running period
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			phase_q <= 5'h00;
		end else begin
			phase_q <= phase_q + 5'h01;
		end
	end
	// Short conversion window each period
	assign meas_busy = (phase_q < 5'h03);
	// Stack is the sum of its cells
	always_comb begin
		stack_mv = 16'h0000;
		for (int k = 0; k < NCAP; k++) begin
			stack_mv = stack_mv + cell_set[k];
		end
	end
	assign cap_mv = cell_set;
	// Load draws constant current while enabled
	assign current_ma = load_enable_out ? -$signed(LOAD_MA) : cur_set;
	assign full_charge_flag = fc_set;
endmodule : scm_stack_model
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb import scm_pkg::*;;
	localparam int TK = 20; // Cycles per tick
	typedef struct packed {logic [15:0] v; logic [15:0] m;} scm_exp_s;
	logic mclk = 0, rst_b = 0, wr_en = 0, rd_en = 0, rd_v = 0, fc = 0, busy_d = 0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wr_data = 16'h0000, init_cap = 16'h0000, rv;
	logic [4:0][15:0] cells = '0, cap_mv;
	logic signed [15:0] cur = 16'sh0000, current_ma;
	logic [15:0] rd_data, stack_mv, nv_d;
	logic meas_busy, fcf, nv_wr, load_en, fault, lvl_h, lvl_l, byp0;
	logic [3:0] byp;
	int err_total = 0, cmp_count = 0;
	scm_exp_s q[$], e;
	////////////////////////////////////////
	scm_manager #(.TICK_CYCLES(TK), .NCAP(5)) dut_u (.mclk(mclk), .rst_b(rst_b), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .stack_mv(stack_mv),
		.current_ma(current_ma), .cap_mv(cap_mv), .meas_busy(meas_busy), .full_charge_flag(fcf),
		.init_cap_dfarad(init_cap), .nv_cap_wr(nv_wr), .nv_cap_data(nv_d),
		.load_enable_out(load_en), .fault_out(fault), .charge_level_bit_high(lvl_h),
		.charge_level_bit_low(lvl_l), .bypass_out(byp), .bottom_cap_bypass_out(byp0));
	scm_stack_model #(.NCAP(5)) model_u (.mclk(mclk), .rst_b(rst_b), .cell_set(cells),
		.cur_set(cur), .fc_set(fc), .load_enable_out(load_en), .stack_mv(stack_mv),
		.current_ma(current_ma), .cap_mv(cap_mv), .meas_busy(meas_busy), .full_charge_flag(fcf));
	// Clock
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// Compare and count
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	// Read answers and bypass during conversions
	always @(posedge mclk) begin
		if (rd_v) begin
			e = q.pop_front();
			chk(rd_data & e.m, e.v & e.m);
		end
		rd_v <= rd_en;
		busy_d <= meas_busy;
		if (busy_d && meas_busy) chk({11'h000, byp, byp0}, 16'h0000);
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [15:0] v, input logic [15:0] m = 16'hffff);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		q.push_back('{v, m});
		@(posedge mclk);
		rd_en <= 1'b0;
	endtask : rd
	task automatic ticks(input int n);
		repeat (n * TK) @(posedge mclk);
	endtask : ticks
	// Sample pins away from conversions
	task automatic pins(input logic [15:0] x);
		@(negedge meas_busy);
		repeat (4) @(posedge mclk);
		chk({7'h00, load_en, fault, lvl_h, lvl_l, byp, byp0}, x);
	endtask : pins
	task automatic cells_to(input logic [15:0] lo, input logic [15:0] hi, input int sp);
		for (int k = 0; k < 5; k++) begin
			if (k != 0 && k != 3) cells[k] <= lo + 16'($urandom % sp);
		end
		cells[0] <= hi + 16'($urandom % sp);
		cells[3] <= hi + 16'($urandom % sp);
	endtask : cells_to
	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
	endtask : do_reset
	task automatic summarize;
		$display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (30000) @(posedge mclk);
		err_total++;
		summarize();
	end
	// Main sequence
	initial begin
		void'($urandom(13141));
		init_cap = 16'h0064 + 16'($urandom % 900);
		cells_to(16'h09c4, 16'h09c4, 1);
		do_reset();
		pins(16'h0000);
		rd(A_CAP, init_cap);
		for (int i = 1; i < 27; i++) begin
			if (i inside {[1:4], [9:15], [19:26]}) rd(5'(i), RST_VAL[i]);
		end
		wr(5'h1e, 16'hbeef);
		rd(5'h1e, 16'h0000);
		rv = 16'($urandom);
		wr(A_ESR_OFS, rv);
		rd(A_ESR_OFS, rv);
		rd(A_CHG_V, 16'h2328);
		cells_to(16'h0578, 16'h0578, 1);
		$display("test registers done");
		cur <= 16'sh01f4;
		ticks(3);
		rd(A_STATUS, 16'h0020, 16'h0030);
		cur <= -16'sh01f4;
		ticks(3);
		rd(A_STATUS, 16'h0010, 16'h0010);
		ticks(1);
		rd(A_STATUS, 16'h0000, 16'h0020);
		cur <= 16'sh01f4;
		ticks(4);
		rd(A_STATUS, 16'h0020, 16'h0030);
		rd(A_RELATIVE_CHARGE_PERCENT, 16'h0032);
		$display("test modes done");
		cells_to(16'h0960, 16'h0a8c, 100);
		ticks(4);
		pins(16'h0000);
		wr(A_CTRL, 16'h0002);
		ticks(4);
		pins(16'h0009);
		cur <= -16'sh01f4;
		ticks(3);
		pins(16'h0000);
		cur <= 16'sh0000;
		fc <= 1'b1;
		ticks(4);
		pins(16'h0009);
		wr(A_CTRL, 16'h0006);
		ticks(3);
		pins(16'h0000);
		fc <= 1'b0;
		cells_to(16'h03e8, 16'h03e8, 1);
		wr(A_CTRL, 16'h0002);
		$display("test balance done");
		wr(A_MAX_CHG_T, 16'h0001);
		wr(A_MAX_DSG_T, 16'h0001);
		wr(A_CTRL, 16'h0003);
		repeat (3) @(posedge mclk);
		rd(A_STATUS, 16'h0001, 16'h000f);
		ticks(5);
		rd(A_STATUS, 16'h0008, 16'h000f);
		wr(A_CTRL, 16'h0003);
		repeat (3) @(posedge mclk);
		rd(A_STATUS, 16'h0001, 16'h000f);
		cells_to(16'h07d0, 16'h07d0, 1);
		pins(16'h0100);
		ticks(5);
		rd(A_STATUS, 16'h0004, 16'h000f);
		pins(16'h0000);
		$display("test learn done");
		do_reset();
		wr(A_CTRL, 16'h0008);
		wr(A_LRN_IVL, 16'h00fa);
		ticks(596);
		rd(A_STATUS, 16'h0000, 16'h0001);
		ticks(8);
		rd(A_STATUS, 16'h0001, 16'h0001);
		repeat (2) @(posedge mclk);
		$display("test interval done");
		summarize();
	end
endmodule : tb
`default_nettype wire
